// File: hdl/hdbus_port.sv
// Purpose: Host data bus direction control and upper address pin roles
// Assumes: Access requests come from same-clock logic; strap pins are static
// Notes: Output enable is high while the device drives the data lines
// Contract
// - Sixteen-bit two-way data path for host register and memory access.
// - Transparent mode also carries protocol words to external memory up to 64K.
// - Data outputs stay undriven unless a drive condition holds.
// - Drive outward on host reads in buffered or transparent mode.
// - Transparent: drive outward on protocol internal access or external write.
// - Transparent: receive on host writes and protocol external reads.
// - Large memory: top upper pin is always address bit fifteen.
// - Large memory: next two pins always address bits fourteen and thirteen.
// - Small memory, strap high: top pin is address bit fifteen.
// - Small memory, strap high: bits fourteen and thirteen are address inputs.
// - Small memory, strap low: top two pins select clock, 10/20/12/16 MHz.
// - Small memory: memory supply pin acts as the upper address strap.
module hdbus_port import hdbus_pkg::*; #(
  parameter bit LARGE_MEM = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic transparent_in,
  input wire logic host_read_in,
  input wire logic host_write_in,
  input wire logic proto_int_access_in,
  input wire logic proto_ext_write_in,
  input wire logic proto_ext_read_in,
  input wire logic [HDBUS_DATA_W-1:0] internal_rdata_in,
  input wire logic [HDBUS_DATA_W-1:0] proto_wdata_in,
  input wire logic [HDBUS_DATA_W-1:0] host_data_lines_in,
  output logic [HDBUS_DATA_W-1:0] host_data_lines_out,
  output logic host_data_lines_oe_out,
  output logic [HDBUS_DATA_W-1:0] inward_data_out,
  output logic inward_valid_out,
  output logic inward_from_ext_out,
  input wire logic address_bit_fifteen_in,
  input wire logic address_bit_fourteen_in,
  input wire logic address_bit_thirteen_in,
  input wire logic upper_address_strap_in,
  output logic [HDBUS_UPPER_W-1:0] upper_addr_out,
  output logic upper_addr_valid_out,
  output logic [1:0] clk_sel_out,
  output logic clk_sel_valid_out,
  output logic bit13_tie_fault_out,
  output logic [2:0] dir_state_out
);
  logic [HDBUS_DATA_W-1:0] data_sync;
  logic [2:0] upper_sync;
  logic strap_sync;
  logic strap_lvl;
  logic [1:0] clk_sel_cap;
  logic strap_done;
  hdbus_dir_e dir_d;
  hdbus_dir_e dir_q;
  logic [HDBUS_DATA_W-1:0] dout_d;
  logic [HDBUS_DATA_W-1:0] dout_q;
  logic oe_q;
  logic [HDBUS_DATA_W-1:0] inward_q;
  logic inward_valid_q;
  logic inward_ext_q;
  logic [HDBUS_UPPER_W-1:0] upper_q;
  logic upper_valid_q;
  logic [1:0] clk_sel_q;
  logic clk_sel_valid_q;
  logic tie_fault_q;

  // Pins are asynchronous to clk_in
  hdbus_sync #(.WIDTH(HDBUS_DATA_W)) u_data_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(host_data_lines_in),
    .sync_out(data_sync)
  );
  hdbus_sync #(.WIDTH(4)) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({upper_address_strap_in, address_bit_fifteen_in,
               address_bit_fourteen_in, address_bit_thirteen_in}),
    .sync_out({strap_sync, upper_sync})
  );
  // Strap is taken once; later changes are ignored by design
  hdbus_strap u_strap (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .strap_in(strap_sync),
    .clk_pins_in(upper_sync[2:1]),
    .strap_out(strap_lvl),
    .clk_sel_out(clk_sel_cap),
    .valid_out(strap_done)
  );

  // Shared by the drive decode and its checks so both agree on drive states
  function automatic logic dir_drives(input hdbus_dir_e dir);
    return (dir == HDBUS_DIR_HOST_READ) || (dir == HDBUS_DIR_PROTO_INT) || (dir == HDBUS_DIR_EXT_WRITE);
  endfunction

  // Direction decode, host read has priority over protocol traffic
  wire host_rd = host_read_in;
  wire proto_int = transparent_in && proto_int_access_in;
  wire ext_wr = transparent_in && proto_ext_write_in;
  wire inward = (host_write_in || (transparent_in && proto_ext_read_in));
  assign dir_d = host_rd ? HDBUS_DIR_HOST_READ :
                 proto_int ? HDBUS_DIR_PROTO_INT :
                 ext_wr ? HDBUS_DIR_EXT_WRITE :
                 inward ? HDBUS_DIR_INWARD : HDBUS_DIR_IDLE;
  assign dout_d = host_rd ? internal_rdata_in : proto_wdata_in;
  wire drive_d = dir_drives(dir_d);

  // Upper pin roles; small part with strap low feeds clock select
  wire addr_role = LARGE_MEM || strap_lvl;
  wire clk_role = !LARGE_MEM && !strap_lvl;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dir_q <= HDBUS_DIR_IDLE;
      dout_q <= HDBUS_DATA_RST;
      oe_q <= 1'b0;
    end else begin
      dir_q <= dir_d;
      dout_q <= drive_d ? dout_d : HDBUS_DATA_RST;
      oe_q <= drive_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      inward_q <= HDBUS_DATA_RST;
      inward_valid_q <= 1'b0;
      inward_ext_q <= 1'b0;
    end else begin
      inward_valid_q <= (dir_d == HDBUS_DIR_INWARD);
      inward_ext_q <= (dir_d == HDBUS_DIR_INWARD) && !host_write_in;
      if (dir_d == HDBUS_DIR_INWARD) begin
        inward_q <= data_sync;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      upper_q <= '0;
      upper_valid_q <= 1'b0;
      clk_sel_q <= HDBUS_CLK_SEL_RST;
      clk_sel_valid_q <= 1'b0;
      tie_fault_q <= 1'b0;
    end else begin
      upper_valid_q <= strap_done && addr_role;
      upper_q <= (strap_done && addr_role) ? upper_sync : '0;
      clk_sel_valid_q <= strap_done && clk_role;
      clk_sel_q <= (strap_done && clk_role) ? clk_sel_cap : HDBUS_CLK_SEL_RST;
      tie_fault_q <= strap_done && clk_role && !upper_sync[0];
    end
  end

  assign host_data_lines_out = dout_q;
  assign host_data_lines_oe_out = oe_q;
  assign inward_data_out = inward_q;
  assign inward_valid_out = inward_valid_q;
  assign inward_from_ext_out = inward_ext_q;
  assign upper_addr_out = upper_q;
  assign upper_addr_valid_out = upper_valid_q;
  assign clk_sel_out = clk_sel_q;
  assign clk_sel_valid_out = clk_sel_valid_q;
  assign bit13_tie_fault_out = tie_fault_q;
  assign dir_state_out = dir_q;

  idle_undriven_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!host_read_in && !(transparent_in && (proto_int_access_in || proto_ext_write_in)))
    |=> !host_data_lines_oe_out) else $error("data lines driven while idle");
  host_read_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
    host_read_in |=> (host_data_lines_oe_out && host_data_lines_out == $past(internal_rdata_in)))
    else $error("host read not driven");
  proto_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (transparent_in && (proto_int_access_in || proto_ext_write_in)) |=> host_data_lines_oe_out)
    else $error("protocol access not driven");
  buffered_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!transparent_in && !host_read_in) |=> !host_data_lines_oe_out)
    else $error("buffered mode drove without host read");
  inward_take_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (host_write_in && !host_read_in && !(transparent_in && (proto_int_access_in || proto_ext_write_in)))
    |=> (inward_valid_out && !host_data_lines_oe_out)) else $error("inward word not taken");
  addr_role_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (LARGE_MEM && strap_done) |=> (upper_addr_valid_out && !clk_sel_valid_out))
    else $error("large part upper pins not address");
  strap_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && strap_lvl) |=> upper_addr_valid_out) else $error("strap high not address");
  clk_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && clk_role) |=> (clk_sel_valid_out && clk_sel_out == $past(clk_sel_cap)
    && !upper_addr_valid_out)) else $error("clock select not presented");
  strap_stable_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && $past(strap_done)) |-> $stable(strap_lvl)) else $error("strap changed after capture");

  // Drive and release of the data lines
  released_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !host_data_lines_oe_out
    |-> (host_data_lines_out == HDBUS_DATA_RST))
    else $error("released lines carry stale data");
  oe_dir_match_a: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1
    |-> (host_data_lines_oe_out == dir_drives(dir_q)))
    else $error("enable disagrees with direction");
  inward_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
    inward_valid_out
    |-> !host_data_lines_oe_out)
    else $error("driving while receiving");
  dir_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!host_read_in && !host_write_in && !transparent_in)
    |=> (dir_state_out == HDBUS_DIR_IDLE))
    else $error("direction not idle");

  // Host reads in either mode
  host_read_dir_a: assert property (@(posedge clk_in) disable iff (rst_in)
    host_read_in
    |=> (dir_state_out == HDBUS_DIR_HOST_READ))
    else $error("host read direction missing");
  buffered_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!transparent_in && host_read_in)
    |=> (host_data_lines_oe_out && dir_state_out == HDBUS_DIR_HOST_READ))
    else $error("buffered host read not driven");

  // Protocol traffic, transparent mode only
  ext_wr_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (transparent_in && proto_ext_write_in && !host_read_in && !proto_int_access_in)
    |=> (host_data_lines_oe_out && host_data_lines_out == $past(proto_wdata_in)))
    else $error("external write word wrong");
  proto_int_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (transparent_in && proto_int_access_in && !host_read_in)
    |=> (dir_state_out == HDBUS_DIR_PROTO_INT && host_data_lines_out == $past(proto_wdata_in)))
    else $error("protocol internal word wrong");
  ext_wr_buffered_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!transparent_in && proto_ext_write_in && !host_read_in)
    |=> !host_data_lines_oe_out)
    else $error("buffered external write drove");
  proto_ignored_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!transparent_in && !host_read_in)
    |=> (dir_state_out == HDBUS_DIR_IDLE || dir_state_out == HDBUS_DIR_INWARD))
    else $error("protocol request taken in buffered mode");

  // Inward words
  ext_read_take_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (transparent_in && proto_ext_read_in && !host_write_in && !host_read_in && !proto_int_access_in
    && !proto_ext_write_in) |=> (inward_valid_out && inward_from_ext_out && !host_data_lines_oe_out))
    else $error("external read word not taken");
  buffered_no_ext_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!transparent_in && !host_write_in)
    |=> !inward_valid_out)
    else $error("inward word without a source");
  inward_host_src_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (host_write_in && dir_d == HDBUS_DIR_INWARD)
    |=> !inward_from_ext_out)
    else $error("host write marked as external");
  inward_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (dir_d == HDBUS_DIR_INWARD)
    |=> (inward_data_out == $past(data_sync)))
    else $error("inward word not captured");
  inward_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (dir_d != HDBUS_DIR_INWARD)
    |=> $stable(inward_data_out))
    else $error("inward word moved without capture");

  // Upper pin roles
  large_top_bit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (LARGE_MEM && strap_done)
    |=> (upper_addr_out[2] == $past(upper_sync[2])))
    else $error("top pin not address");
  large_low_bits_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (LARGE_MEM && strap_done)
    |=> (upper_addr_out[1:0] == $past(upper_sync[1:0])))
    else $error("lower upper pins not address");
  addr_idle_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !upper_addr_valid_out
    |-> (upper_addr_out == '0))
    else $error("address shown outside address role");
  addr_track_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && addr_role)
    |=> (upper_addr_out == $past(upper_sync)))
    else $error("address pins not tracked");
  strap_high_clk_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && strap_lvl)
    |=> !clk_sel_valid_out)
    else $error("clock select with strap high");
  clk_idle_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !clk_sel_valid_out
    |-> (clk_sel_out == HDBUS_CLK_SEL_RST))
    else $error("clock code shown outside clock role");
  roles_apart_a: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1
    |-> !(upper_addr_valid_out && clk_sel_valid_out))
    else $error("both pin roles at once");
  no_role_early_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !strap_done
    |=> (!upper_addr_valid_out && !clk_sel_valid_out))
    else $error("pin role before strap capture");

  // System ties and fixed straps
  tie_fault_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && clk_role && !upper_sync[0])
    |=> bit13_tie_fault_out)
    else $error("missing bit thirteen tie not flagged");
  tie_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!strap_done || !clk_role || upper_sync[0])
    |=> !bit13_tie_fault_out)
    else $error("false bit thirteen tie fault");
  strap_held_a: assert property (@(posedge clk_in) disable iff (rst_in)
    strap_done
    |=> strap_done)
    else $error("strap capture lost");
  clk_code_held_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (strap_done && $past(strap_done))
    |-> $stable(clk_sel_cap))
    else $error("clock code changed after capture");
endmodule

// File: hdl/hdbus_pkg.sv
// Purpose: Shared constants for the host data bus and strap pin block
// Assumes: One device clock; straps are static after power-up
// Notes: Clock select codes are high:low of the two top upper pins
package hdbus_pkg;
  localparam int HDBUS_DATA_W = 16;
  localparam int HDBUS_UPPER_W = 3;
  localparam int HDBUS_SYNC_STAGES = 2;
  localparam logic [1:0] HDBUS_CLK_10MHZ = 2'h0;
  localparam logic [1:0] HDBUS_CLK_20MHZ = 2'h1;
  localparam logic [1:0] HDBUS_CLK_12MHZ = 2'h2;
  localparam logic [1:0] HDBUS_CLK_16MHZ = 2'h3;
  localparam logic [HDBUS_DATA_W-1:0] HDBUS_DATA_RST = 16'h0000;
  localparam logic [1:0] HDBUS_CLK_SEL_RST = 2'h0;
  localparam logic [3:0] HDBUS_STRAP_SETTLE = 4'h4;
  typedef enum logic [2:0] {
    HDBUS_DIR_IDLE,
    HDBUS_DIR_HOST_READ,
    HDBUS_DIR_PROTO_INT,
    HDBUS_DIR_EXT_WRITE,
    HDBUS_DIR_INWARD
  } hdbus_dir_e;
endpackage

// File: hdl/hdbus_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_in
// Notes: First stage feeds only the second stage
module hdbus_sync import hdbus_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule

// File: hdl/hdbus_strap.sv
// Purpose: Captures the upper address strap and clock select straps
// Assumes: Synchronised pins; straps fixed after power-up
// Notes: Capture happens once, after a short settle count following reset
module hdbus_strap import hdbus_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic strap_in,
  input wire logic [1:0] clk_pins_in,
  output logic strap_out,
  output logic [1:0] clk_sel_out,
  output logic valid_out
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic done_q;
  logic strap_q;
  logic [1:0] clk_sel_q;
  wire settle_end = (cnt_q == HDBUS_STRAP_SETTLE);
  assign cnt_d = done_q ? cnt_q : cnt_q + 4'h1;
  // Levels latched after release, never under reset, since straps are pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      strap_q <= 1'b0;
      clk_sel_q <= HDBUS_CLK_SEL_RST;
    end else begin
      cnt_q <= cnt_d;
      if (settle_end && !done_q) begin
        done_q <= 1'b1;
        strap_q <= strap_in;
        clk_sel_q <= clk_pins_in;
      end
    end
  end
  assign strap_out = strap_q;
  assign clk_sel_out = clk_sel_q;
  assign valid_out = done_q;
endmodule

// File: dv/hdbus_host_model.sv
// Purpose: Host and external memory side of the shared data lines
// Assumes: Host or external memory drives only while the device does not
// Notes: Released lines show a pattern that flips every cycle, never held data
module hdbus_host_model (
  input wire logic clk_in,
  input wire logic [15:0] dev_word_in,
  input wire logic dev_oe_in,
  input wire logic drive_in,
  input wire logic [15:0] word_in,
  output logic [15:0] wire_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] idle_q = 16'h0000;
  // A floating bus must not pass for the last word driven
  always @(posedge clk_in) idle_q <= ~idle_q;
  // Host write or external memory read drives the lines inward
  assign wire_out = dev_oe_in ? dev_word_in : (drive_in ? word_in : idle_q);
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench for the data line direction and strap roles
// Assumes: Small memory variant; straps change across a reset, except one late strap change
// Notes: Random request mixes plus directed strap and inward cases
module tb;
  import hdbus_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, tr = 1'b0, hr = 1'b0, hw = 1'b0, pi = 1'b0, pew = 1'b0, per = 1'b0;
  logic drv = 1'b0, ab15 = 1'b0, ab14 = 1'b0, ab13 = 1'b1, strap = 1'b0;
  logic oe, ival, iext, uav, csv, tie;
  logic [15:0] rd = 16'h0000, wd = 16'h0000, hword = 16'h0000, pins, dout, idat;
  logic [2:0] ua, dir;
  logic [1:0] cs;
  logic [31:0] r;
  logic [19:0] e;
  integer seed = 92, miscompares = 0, compares = 0, i, k;
  always #2.5 clk = ~clk;
  hdbus_port #(.LARGE_MEM(1'b0)) hdbus_port_i (.clk_in(clk), .rst_in(rst), .transparent_in(tr),
    .host_read_in(hr), .host_write_in(hw), .proto_int_access_in(pi), .proto_ext_write_in(pew),
    .proto_ext_read_in(per), .internal_rdata_in(rd), .proto_wdata_in(wd), .host_data_lines_in(pins),
    .host_data_lines_out(dout), .host_data_lines_oe_out(oe), .inward_data_out(idat),
    .inward_valid_out(ival), .inward_from_ext_out(iext), .address_bit_fifteen_in(ab15),
    .address_bit_fourteen_in(ab14), .address_bit_thirteen_in(ab13), .upper_address_strap_in(strap),
    .upper_addr_out(ua), .upper_addr_valid_out(uav), .clk_sel_out(cs), .clk_sel_valid_out(csv),
    .bit13_tie_fault_out(tie), .dir_state_out(dir));
  hdbus_host_model hdbus_host_model_i (.clk_in(clk), .dev_word_in(dout), .dev_oe_in(oe),
    .drive_in(drv), .word_in(hword), .wire_out(pins));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Straps are only re-read across a reset, so each strap case restarts
  task automatic restart(input logic s, input logic [2:0] p);
    strap = s;
    {ab15, ab14, ab13} = p;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(8);
  endtask
  // Expected {direction, enable, word} one cycle after the requests
  function automatic logic [19:0] expect_drive(input logic t, h, p, w, input logic [15:0] rdv, wdv);
    if (h) return {3'h1, 1'b1, rdv};
    if (t && p) return {3'h2, 1'b1, wdv};
    if (t && w) return {3'h3, 1'b1, wdv};
    return 20'h00000;
  endfunction
  initial begin
    cyc(16);
    chk({dir, oe, dout}, 20'h00000);
    rst = 1'b0;
    for (k = 0; k < 4; k++) begin
      restart(1'b0, {k[1:0], 1'b1});
      chk({csv, uav, tie, cs}, {3'b100, k[1:0]});
    end
    restart(1'b0, 3'b010);
    chk({csv, tie, cs}, {2'b11, 2'b01});
    restart(1'b1, 3'b101);
    chk({uav, csv, ua}, {2'b10, 3'b101});
    // A late strap change must not move the pins back to clock select
    strap = 1'b0;
    {ab15, ab14, ab13} = 3'b010;
    cyc(4);
    chk({uav, csv, ua}, {2'b10, 3'b010});
    tr = 1'b1;
    hw = 1'b1;
    drv = 1'b1;
    hword = 16'hA5C3;
    cyc(4);
    chk({oe, ival, iext, idat}, {3'b010, 16'hA5C3});
    hw = 1'b0;
    per = 1'b1;
    hword = 16'h3C5A;
    cyc(4);
    chk({oe, ival, iext, idat}, {3'b011, 16'h3C5A});
    per = 1'b0;
    drv = 1'b0;
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      {tr, hr, pi, pew} = r[3:0];
      rd = r[31:16];
      wd = ~r[27:12];
      e = expect_drive(tr, hr, pi, pew, rd, wd);
      cyc(1);
      chk({dir, oe, dout}, e);
    end
    conclude;
  end
  initial begin
    #(20000 * 5);
    miscompares++;
    conclude;
  end
endmodule
